// >>> bench/asid_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module asid_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic fetch_valid,
    input wire logic fetch_ready,
    input wire logic exec_ready,
    input wire logic decode_valid,
    input wire asid_pkg::asid_op_t decode_op,
    input wire logic decode_word,
    input wire logic decode_memory,
    input wire logic [asid_pkg::CYC_W-1:0] decode_clocks
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_last_byte;
        fetch_valid && fetch_ready ##1 !fetch_ready && !decode_valid;
    endsequence
    a_answer_time: assert property (s_last_byte |=> decode_valid)
        else $error("result late");
    a_hold_result: assert property (decode_valid && !exec_ready |=> decode_valid
        && $stable(decode_op) && $stable(decode_clocks)) else $error("result moved");
    a_release_next: assert property (decode_valid && exec_ready |=> !decode_valid
        && fetch_ready) else $error("result not released");
    a_refuse_busy: assert property (decode_valid |-> !fetch_ready)
        else $error("byte taken while busy");
    a_mul_clocks: assert property (decode_valid &&
        decode_op inside {asid_pkg::product_unsigned_op, asid_pkg::product_signed_op}
        |-> decode_clocks == (decode_memory ? (decode_word ? 9'h018 : 9'h010)
        : (decode_word ? 9'h015 : 9'h00d))) else $error("multiply clocks");
    a_div_clocks: assert property (decode_valid &&
        decode_op == asid_pkg::quotient_unsigned_op |-> decode_clocks == (decode_memory
        ? (decode_word ? 9'h019 : 9'h011) : (decode_word ? 9'h016 : 9'h00e)))
        else $error("divide clocks");
    a_quotient_signed_op_clocks: assert property (decode_valid &&
        decode_op == asid_pkg::quotient_signed_op |-> decode_clocks == (decode_memory
        ? (decode_word ? 9'h01c : 9'h014) : (decode_word ? 9'h019 : 9'h011)))
        else $error("signed divide clocks");
    a_shift_one: assert property (decode_valid &&
        decode_op == asid_pkg::shift_by_one_op |-> decode_clocks ==
        (decode_memory ? 9'h007 : 9'h002)) else $error("shift clocks");
endmodule
bind asid_decoder asid_checker u_asid_checker (.clk(clk), .srst(srst),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .exec_ready(exec_ready),
    .decode_valid(decode_valid), .decode_op(decode_op), .decode_word(decode_word),
    .decode_memory(decode_memory), .decode_clocks(decode_clocks));
`default_nettype wire

// >>> bench/asid_partner.sv
`timescale 1ns/10ps
`default_nettype none
module asid_partner (
    input wire logic clk,
    input wire logic fetch_ready,
    output logic fetch_valid,
    output logic [7:0] fetch_byte,
    output logic exec_ready
);
    logic [7:0] q[$];
    logic stall = 1'b0;
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask
    initial begin
        fetch_valid = 1'b0;
        fetch_byte = 8'h00;
        exec_ready = 1'b1;
    end
    // idle byte lane flips every cycle
    always @(posedge clk) begin
        if (fetch_valid && fetch_ready) void'(q.pop_front());
        #1;
        fetch_valid = q.size() != 0;
        fetch_byte = (q.size() != 0) ? q[0] : ~fetch_byte;
        exec_ready = !stall;
    end
endmodule
`default_nettype wire

// >>> bench/tb_arith_shift_instr_decode.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_arith_shift_instr_decode;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] count_low_register = 8'h03;
    logic fetch_valid, fetch_ready, exec_ready, decode_valid, decode_word, decode_memory;
    logic [7:0] fetch_byte;
    asid_pkg::asid_op_t decode_op;
    logic [asid_pkg::CYC_W-1:0] decode_clocks;
    logic decode_reg_is_dest;
    logic [1:0] decode_mod;
    logic [2:0] decode_reg, decode_rm, shift_kind_field;
    logic [15:0] decode_disp, decode_imm;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    asid_decoder u_asid_decoder (.clk(clk), .srst(srst), .fetch_valid(fetch_valid),
        .fetch_byte(fetch_byte), .fetch_ready(fetch_ready),
        .count_low_register(count_low_register), .exec_ready(exec_ready),
        .decode_valid(decode_valid), .decode_op(decode_op), .decode_word(decode_word),
        .decode_reg_is_dest(decode_reg_is_dest), .decode_memory(decode_memory),
        .decode_mod(decode_mod), .decode_reg(decode_reg), .decode_rm(decode_rm),
        .shift_kind_field(shift_kind_field), .decode_disp(decode_disp),
        .decode_imm(decode_imm),
        .decode_clocks(decode_clocks));
    asid_partner u_asid_partner (.clk(clk), .fetch_ready(fetch_ready),
        .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .exec_ready(exec_ready));
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // f = {check word, memory, word}
    task automatic dec(input int n, input logic [47:0] b, input asid_pkg::asid_op_t op,
            input logic [8:0] ck, input logic [2:0] f);
        int i;
        for (i = 0; i < n; i++) u_asid_partner.push(b[8*(n-1-i) +: 8]);
        for (i = 0; i < 30 && decode_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        `CHK("op", op, decode_op)
        `CHK("clocks", ck, decode_clocks)
        `CHK("memory", f[1], decode_memory)
        if (f[2]) `CHK("word", f[0], decode_word)
        @(posedge clk);
        #1;
    endtask
    task automatic t_sub;
        dec(2, 48'h2bc1, asid_pkg::op_subtract, 9'h002, 3'h5);
        `CHK("dest", 1'b1, decode_reg_is_dest)
        dec(4, 48'h2b1e3412, asid_pkg::op_subtract, 9'h007, 3'h7);
        `CHK("modrm", 8'h1e, {decode_mod, decode_reg, decode_rm})
        `CHK("disp", 16'h1234, decode_disp)
        dec(3, 48'h83e805, asid_pkg::op_subtract, 9'h003, 3'h5);
        dec(3, 48'h2d3412, asid_pkg::op_subtract, 9'h003, 3'h5);
        dec(2, 48'h19c1, asid_pkg::difference_with_borrow_op, 9'h002, 3'h5);
        `CHK("dest", 1'b0, decode_reg_is_dest)
        dec(4, 48'h81d83412, asid_pkg::difference_with_borrow_op, 9'h003, 3'h5);
        `CHK("imm", 16'h1234, decode_imm)
        dec(2, 48'h1c05, asid_pkg::difference_with_borrow_op, 9'h003, 3'h4);
        dec(2, 48'h83f8, asid_pkg::op_illegal, 9'h000, 3'h0);
        $display("t_sub done");
    endtask
    task automatic t_adj;
        dec(1, 48'h37, asid_pkg::unpacked_decimal_add_fix, 9'h003, 3'h0);
        dec(1, 48'h27, asid_pkg::packed_decimal_add_fix, 9'h003, 3'h0);
        dec(1, 48'h3f, asid_pkg::unpacked_decimal_minus_fix, 9'h003, 3'h0);
        dec(1, 48'h2f, asid_pkg::packed_decimal_minus_fix, 9'h003, 3'h0);
        dec(2, 48'hd40a, asid_pkg::unpacked_decimal_product_fix, 9'h010, 3'h0);
        dec(2, 48'hd50a, asid_pkg::unpacked_decimal_quotient_prep, 9'h00e, 3'h0);
        dec(1, 48'h98, asid_pkg::byte_to_word_extend, 9'h002, 3'h0);
        dec(1, 48'h90, asid_pkg::op_illegal, 9'h000, 3'h0);
        dec(2, 48'hd40b, asid_pkg::op_illegal, 9'h000, 3'h0);
        $display("t_adj done");
    endtask
    task automatic t_muldiv;
        dec(2, 48'hf6e1, asid_pkg::product_unsigned_op, 9'h00d, 3'h4);
        dec(3, 48'hf76185, asid_pkg::product_unsigned_op, 9'h018, 3'h7);
        `CHK("disp8", 16'hff85, decode_disp)
        dec(2, 48'hf7e9, asid_pkg::product_signed_op, 9'h015, 3'h5);
        dec(2, 48'hf629, asid_pkg::product_signed_op, 9'h010, 3'h6);
        dec(3, 48'h6bc105, asid_pkg::product_signed_imm_op, 9'h015, 3'h5);
        dec(4, 48'h69073412, asid_pkg::product_signed_imm_op, 9'h018, 3'h7);
        dec(2, 48'hf6f1, asid_pkg::quotient_unsigned_op, 9'h00e, 3'h4);
        dec(2, 48'hf731, asid_pkg::quotient_unsigned_op, 9'h019, 3'h7);
        dec(2, 48'hf6f9, asid_pkg::quotient_signed_op, 9'h011, 3'h4);
        dec(2, 48'hf739, asid_pkg::quotient_signed_op, 9'h01c, 3'h7);
        $display("t_muldiv done");
    endtask
    task automatic t_shift;
        dec(2, 48'hd0e0, asid_pkg::shift_by_one_op, 9'h002, 3'h4);
        `CHK("kind", 3'h4, shift_kind_field)
        dec(2, 48'hd128, asid_pkg::shift_by_one_op, 9'h007, 3'h7);
        `CHK("kind", 3'h5, shift_kind_field)
        dec(2, 48'hd2e0, asid_pkg::shift_by_count_low_op, 9'h008, 3'h4);
        count_low_register = 8'h10;
        dec(2, 48'hd320, asid_pkg::shift_by_count_low_op, 9'h018, 3'h7);
        dec(3, 48'hc0e005, asid_pkg::shift_by_imm_op, 9'h00a, 3'h4);
        `CHK("count", 16'h0005, decode_imm)
        $display("t_shift done");
    endtask
    task automatic t_stall;
        u_asid_partner.stall = 1'b1;
        u_asid_partner.push(8'h99);
        repeat (8) @(posedge clk);
        #1;
        `CHK("held valid", 1'b1, decode_valid)
        `CHK("held ready", 1'b0, fetch_ready)
        `CHK("held op", asid_pkg::word_to_doubleword_extend, decode_op)
        `CHK("held clocks", 9'h002, decode_clocks)
        u_asid_partner.stall = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK("released", 1'b0, decode_valid)
        $display("t_stall done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        #1;
        srst = 1'b0;
        t_sub();
        t_adj();
        t_muldiv();
        t_shift();
        t_stall();
        summarize();
    end
endmodule
`default_nettype wire

// >>> logic/asid_decoder.sv
`timescale 1ns/10ps
`default_nettype none

module asid_decoder (
    input wire logic clk,
    input wire logic srst,
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_byte,
    output logic fetch_ready,
    input wire logic [7:0] count_low_register,
    input wire logic exec_ready,
    output logic decode_valid,
    output asid_pkg::asid_op_t decode_op,
    output logic decode_word,
    output logic decode_reg_is_dest,
    output logic decode_memory,
    output logic [1:0] decode_mod,
    output logic [2:0] decode_reg,
    output logic [2:0] decode_rm,
    output logic [2:0] shift_kind_field,
    output logic [15:0] decode_disp,
    output logic [15:0] decode_imm,
    output logic [asid_pkg::CYC_W-1:0] decode_clocks
);
    typedef enum {
        st_opcode,
        st_modrm,
        st_disp_lo,
        st_disp_hi,
        st_imm_lo,
        st_imm_hi,
        st_second,
        st_cost,
        st_done
    } asid_state_t;

    asid_state_t state;
    asid_state_t next_state;
    asid_pkg::asid_op_t op;
    asid_pkg::asid_op_t first_op;
    asid_pkg::asid_op_t modrm_op;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [15:0] disp;
    logic [15:0] imm;
    logic has_modrm;
    logic [1:0] imm_count;
    logic [1:0] disp_count;
    logic [1:0] disp_count_q;
    logic first_modrm;
    logic first_second;
    logic [1:0] first_imm;
    logic take;
    logic rm_form;
    logic mem_now;
    logic [7:0] count_n;
    logic [asid_pkg::CYC_W-1:0] cycles;

    assign take = fetch_valid && fetch_ready;
    assign decode_valid = (state == st_done);

    always_comb begin
        unique case (state)
            st_opcode, st_modrm, st_disp_lo, st_disp_hi, st_imm_lo, st_imm_hi,
            st_second: fetch_ready = 1'b1;
            st_cost, st_done: fetch_ready = 1'b0;
        endcase
    end

    // classify the first byte
    always_comb begin
        first_op = asid_pkg::op_illegal;
        first_modrm = 1'b0;
        first_second = 1'b0;
        first_imm = 2'd0;
        if (fetch_byte[7:2] == asid_pkg::OPC_SUB_RM) begin
            first_op = asid_pkg::op_subtract;
            first_modrm = 1'b1;
        end else if (fetch_byte[7:2] == asid_pkg::OPC_BRW_RM) begin
            first_op = asid_pkg::difference_with_borrow_op;
            first_modrm = 1'b1;
        end else if (fetch_byte[7:2] == asid_pkg::OPC_GRP_IMM) begin
            first_modrm = 1'b1;
            first_imm = (fetch_byte[1:0] == asid_pkg::SW_WORD_IMM) ? 2'd2 : 2'd1;
        end else if (fetch_byte[7:1] == asid_pkg::OPC_SUB_ACC) begin
            first_op = asid_pkg::op_subtract;
            first_imm = fetch_byte[0] ? 2'd2 : 2'd1;
        end else if (fetch_byte[7:1] == asid_pkg::OPC_BRW_ACC) begin
            first_op = asid_pkg::difference_with_borrow_op;
            first_imm = fetch_byte[0] ? 2'd2 : 2'd1;
        end else if (fetch_byte == asid_pkg::OPC_UNP_ADD_FIX) begin
            first_op = asid_pkg::unpacked_decimal_add_fix;
        end else if (fetch_byte == asid_pkg::OPC_PKD_ADD_FIX) begin
            first_op = asid_pkg::packed_decimal_add_fix;
        end else if (fetch_byte == asid_pkg::OPC_UNP_MINUS_FIX) begin
            first_op = asid_pkg::unpacked_decimal_minus_fix;
        end else if (fetch_byte == asid_pkg::OPC_PKD_MINUS_FIX) begin
            first_op = asid_pkg::packed_decimal_minus_fix;
        end else if (fetch_byte[7:1] == asid_pkg::OPC_GRP_MULDIV) begin
            first_modrm = 1'b1;
        end else if (fetch_byte[7:2] == asid_pkg::OPC_PRD_IMM && fetch_byte[0]) begin
            first_op = asid_pkg::product_signed_imm_op;
            first_modrm = 1'b1;
            first_imm = fetch_byte[1] ? 2'd1 : 2'd2;
        end else if (fetch_byte == asid_pkg::OPC_PRODUCT_FIX) begin
            first_op = asid_pkg::unpacked_decimal_product_fix;
            first_second = 1'b1;
        end else if (fetch_byte == asid_pkg::OPC_QUOTIENT_PREP) begin
            first_op = asid_pkg::unpacked_decimal_quotient_prep;
            first_second = 1'b1;
        end else if (fetch_byte == asid_pkg::OPC_BYTE_EXTEND) begin
            first_op = asid_pkg::byte_to_word_extend;
        end else if (fetch_byte == asid_pkg::OPC_WORD_EXTEND) begin
            first_op = asid_pkg::word_to_doubleword_extend;
        end else if (fetch_byte[7:1] == asid_pkg::OPC_SHIFT_ONE) begin
            first_op = asid_pkg::shift_by_one_op;
            first_modrm = 1'b1;
        end else if (fetch_byte[7:1] == asid_pkg::OPC_SHIFT_CNT) begin
            first_op = asid_pkg::shift_by_count_low_op;
            first_modrm = 1'b1;
        end else if (fetch_byte[7:1] == asid_pkg::OPC_SHIFT_IMM) begin
            first_op = asid_pkg::shift_by_imm_op;
            first_modrm = 1'b1;
            first_imm = 2'd1;
        end
    end

    // group opcodes resolve on the modrm reg field
    always_comb begin
        modrm_op = op;
        if (opcode[7:2] == asid_pkg::OPC_GRP_IMM) begin
            if (fetch_byte[5:3] == asid_pkg::REG_SUB) begin
                modrm_op = asid_pkg::op_subtract;
            end else if (fetch_byte[5:3] == asid_pkg::REG_BRW) begin
                modrm_op = asid_pkg::difference_with_borrow_op;
            end else begin
                modrm_op = asid_pkg::op_illegal;
            end
        end else if (opcode[7:1] == asid_pkg::OPC_GRP_MULDIV) begin
            unique case (fetch_byte[5:3])
                asid_pkg::REG_PRD_U: modrm_op = asid_pkg::product_unsigned_op;
                asid_pkg::REG_PRD_S: modrm_op = asid_pkg::product_signed_op;
                asid_pkg::REG_DIV: modrm_op = asid_pkg::quotient_unsigned_op;
                asid_pkg::REG_QUO_S: modrm_op = asid_pkg::quotient_signed_op;
                default: modrm_op = asid_pkg::op_illegal;
            endcase
        end
    end

    // displacement length of the incoming modrm byte
    always_comb begin
        if (fetch_byte[7:6] == asid_pkg::MOD_DISP8) begin
            disp_count = 2'd1;
        end else if (fetch_byte[7:6] == asid_pkg::MOD_REGISTER) begin
            disp_count = 2'd0;
        end else if (fetch_byte[7:6] == asid_pkg::MOD_NO_DISP
                && fetch_byte[2:0] != asid_pkg::RM_DIRECT) begin
            disp_count = 2'd0;
        end else begin
            disp_count = 2'd2;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            st_opcode: begin
                if (take) begin
                    if (first_modrm) begin
                        next_state = st_modrm;
                    end else if (first_second) begin
                        next_state = st_second;
                    end else if (first_imm != 2'd0) begin
                        next_state = st_imm_lo;
                    end else begin
                        next_state = st_cost;
                    end
                end
            end
            st_modrm: begin
                if (take) begin
                    if (modrm_op == asid_pkg::op_illegal) begin
                        next_state = st_cost;
                    end else if (disp_count != 2'd0) begin
                        next_state = st_disp_lo;
                    end else if (imm_count != 2'd0) begin
                        next_state = st_imm_lo;
                    end else begin
                        next_state = st_cost;
                    end
                end
            end
            st_disp_lo: begin
                if (take) begin
                    if (disp_count_q == 2'd2) begin
                        next_state = st_disp_hi;
                    end else if (imm_count != 2'd0) begin
                        next_state = st_imm_lo;
                    end else begin
                        next_state = st_cost;
                    end
                end
            end
            st_disp_hi: begin
                if (take) begin
                    next_state = (imm_count != 2'd0) ? st_imm_lo : st_cost;
                end
            end
            st_imm_lo: begin
                if (take) begin
                    next_state = (imm_count == 2'd2) ? st_imm_hi : st_cost;
                end
            end
            st_imm_hi, st_second: begin
                if (take) begin
                    next_state = st_cost;
                end
            end
            st_cost: next_state = st_done;
            st_done: begin
                if (exec_ready) begin
                    next_state = st_opcode;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= st_opcode;
        end else begin
            state <= next_state;
        end
    end

    // instruction byte capture
    always_ff @(posedge clk) begin
        if (srst) begin
            op <= asid_pkg::op_illegal;
            opcode <= 8'h00;
            modrm <= 8'h00;
            disp <= 16'h0000;
            imm <= 16'h0000;
            has_modrm <= 1'b0;
            imm_count <= 2'd0;
            disp_count_q <= 2'd0;
        end else if (take) begin
            unique case (state)
                st_opcode: begin
                    op <= first_op;
                    opcode <= fetch_byte;
                    modrm <= 8'h00;
                    disp <= 16'h0000;
                    imm <= 16'h0000;
                    has_modrm <= first_modrm;
                    imm_count <= first_imm;
                    disp_count_q <= 2'd0;
                end
                st_modrm: begin
                    op <= modrm_op;
                    modrm <= fetch_byte;
                    disp_count_q <= disp_count;
                end
                st_disp_lo: disp <= {{8{fetch_byte[7]}}, fetch_byte};
                st_disp_hi: disp[15:8] <= fetch_byte;
                st_imm_lo: imm <= {8'h00, fetch_byte};
                st_imm_hi: imm[15:8] <= fetch_byte;
                st_second: begin
                    // second byte must be the base ten
                    if (fetch_byte != asid_pkg::OPC_ADJ_BASE) begin
                        op <= asid_pkg::op_illegal;
                    end
                end
                st_cost, st_done: begin
                end
            endcase
        end
    end

    assign mem_now = has_modrm && (modrm[7:6] != asid_pkg::MOD_REGISTER);
    assign rm_form = (opcode[7:2] == asid_pkg::OPC_SUB_RM)
        || (opcode[7:2] == asid_pkg::OPC_BRW_RM);
    // count register sampled as the instruction completes
    assign count_n = (op == asid_pkg::shift_by_imm_op) ? imm[7:0]
        : count_low_register;

    asid_cycle_calc u_cycle_calc (
        .op(op),
        .memory(mem_now),
        .word(opcode[0]),
        .with_imm(imm_count != 2'd0),
        .count_n(count_n),
        .cycles(cycles)
    );

    // result latch, held while the datapath stalls
    always_ff @(posedge clk) begin
        if (srst) begin
            decode_op <= asid_pkg::op_illegal;
            decode_word <= 1'b0;
            decode_reg_is_dest <= 1'b0;
            decode_memory <= 1'b0;
            decode_mod <= 2'h0;
            decode_reg <= 3'h0;
            decode_rm <= 3'h0;
            shift_kind_field <= 3'h0;
            decode_disp <= 16'h0000;
            decode_imm <= 16'h0000;
            decode_clocks <= '0;
        end else if (state == st_cost) begin
            decode_op <= op;
            decode_word <= opcode[0];
            decode_reg_is_dest <= rm_form ? opcode[1]
                : (op == asid_pkg::product_signed_imm_op);
            decode_memory <= mem_now;
            decode_mod <= modrm[7:6];
            decode_reg <= modrm[5:3];
            decode_rm <= modrm[2:0];
            if (op == asid_pkg::shift_by_one_op || op == asid_pkg::shift_by_count_low_op
                    || op == asid_pkg::shift_by_imm_op) begin
                shift_kind_field <= modrm[5:3];
            end else begin
                shift_kind_field <= 3'h0;
            end
            decode_disp <= disp;
            decode_imm <= imm;
            decode_clocks <= cycles;
        end
    end
endmodule

`default_nettype wire

// >>> logic/asid_defs.sv
package asid_pkg;
    typedef enum logic [4:0] {
        op_illegal,
        op_subtract,
        difference_with_borrow_op,
        unpacked_decimal_add_fix,
        packed_decimal_add_fix,
        unpacked_decimal_minus_fix,
        packed_decimal_minus_fix,
        product_unsigned_op,
        product_signed_op,
        product_signed_imm_op,
        quotient_unsigned_op,
        quotient_signed_op,
        unpacked_decimal_product_fix,
        unpacked_decimal_quotient_prep,
        byte_to_word_extend,
        word_to_doubleword_extend,
        shift_by_one_op,
        shift_by_count_low_op,
        shift_by_imm_op
    } asid_op_t;

    // opcode patterns, the 6- and 7-bit ones compared on the upper bits
    localparam logic [5:0] OPC_SUB_RM = 6'h0a;
    localparam logic [5:0] OPC_BRW_RM = 6'h06;
    localparam logic [5:0] OPC_GRP_IMM = 6'h20;
    localparam logic [6:0] OPC_SUB_ACC = 7'h16;
    localparam logic [6:0] OPC_BRW_ACC = 7'h0e;
    localparam logic [7:0] OPC_UNP_ADD_FIX = 8'h37;
    localparam logic [7:0] OPC_PKD_ADD_FIX = 8'h27;
    localparam logic [7:0] OPC_UNP_MINUS_FIX = 8'h3f;
    localparam logic [7:0] OPC_PKD_MINUS_FIX = 8'h2f;
    localparam logic [6:0] OPC_GRP_MULDIV = 7'h7b;
    localparam logic [5:0] OPC_PRD_IMM = 6'h1a;
    localparam logic [7:0] OPC_PRODUCT_FIX = 8'hd4;
    localparam logic [7:0] OPC_QUOTIENT_PREP = 8'hd5;
    localparam logic [7:0] OPC_ADJ_BASE = 8'h0a;
    localparam logic [7:0] OPC_BYTE_EXTEND = 8'h98;
    localparam logic [7:0] OPC_WORD_EXTEND = 8'h99;
    localparam logic [6:0] OPC_SHIFT_ONE = 7'h68;
    localparam logic [6:0] OPC_SHIFT_CNT = 7'h69;
    localparam logic [6:0] OPC_SHIFT_IMM = 7'h60;

    // modrm reg, mod and rm field selectors, and the imm s/w bits
    localparam logic [2:0] REG_SUB = 3'h5;
    localparam logic [2:0] REG_BRW = 3'h3;
    localparam logic [2:0] REG_PRD_U = 3'h4;
    localparam logic [2:0] REG_PRD_S = 3'h5;
    localparam logic [2:0] REG_DIV = 3'h6;
    localparam logic [2:0] REG_QUO_S = 3'h7;
    localparam logic [1:0] MOD_REGISTER = 2'h3;
    localparam logic [1:0] MOD_NO_DISP = 2'h0;
    localparam logic [1:0] MOD_DISP8 = 2'h1;
    localparam logic [2:0] RM_DIRECT = 3'h6;
    localparam logic [1:0] SW_WORD_IMM = 2'h1;

    // execution clock counts
    localparam int CYC_W = 9;
    localparam logic [8:0] CLK_ALU_REG = 9'h002;
    localparam logic [8:0] CLK_ALU_IMM = 9'h003;
    localparam logic [8:0] CLK_ALU_MEM = 9'h007;
    localparam logic [8:0] CLK_ADJUST = 9'h003;
    localparam logic [8:0] CLK_PRD_RB = 9'h00d;
    localparam logic [8:0] CLK_PRD_RW = 9'h015;
    localparam logic [8:0] CLK_PRD_MB = 9'h010;
    localparam logic [8:0] CLK_PRD_MW = 9'h018;
    localparam logic [8:0] CLK_MULI_REG = 9'h015;
    localparam logic [8:0] CLK_MULI_MEM = 9'h018;
    localparam logic [8:0] CLK_DIV_RB = 9'h00e;
    localparam logic [8:0] CLK_DIV_RW = 9'h016;
    localparam logic [8:0] CLK_DIV_MB = 9'h011;
    localparam logic [8:0] CLK_DIV_MW = 9'h019;
    localparam logic [8:0] CLK_QUOS_RB = 9'h011;
    localparam logic [8:0] CLK_QUOS_RW = 9'h019;
    localparam logic [8:0] CLK_QUOS_MB = 9'h014;
    localparam logic [8:0] CLK_QUOS_MW = 9'h01c;
    localparam logic [8:0] CLK_PRODUCT_FIX = 9'h010;
    localparam logic [8:0] CLK_QUOTIENT_PREP = 9'h00e;
    localparam logic [8:0] CLK_EXTEND = 9'h002;
    localparam logic [8:0] CLK_SHIFT1_REG = 9'h002;
    localparam logic [8:0] CLK_SHIFT1_MEM = 9'h007;
    localparam logic [8:0] CLK_SHIFTN_REG = 9'h005;
    localparam logic [8:0] CLK_SHIFTN_MEM = 9'h008;
endpackage

`timescale 1ns/10ps
`default_nettype none

module asid_cycle_calc (
    input wire asid_pkg::asid_op_t op,
    input wire logic memory,
    input wire logic word,
    input wire logic with_imm,
    input wire logic [7:0] count_n,
    output logic [asid_pkg::CYC_W-1:0] cycles
);
    always_comb begin
        unique case (op)
            asid_pkg::op_subtract, asid_pkg::difference_with_borrow_op: begin
                if (memory) begin
                    cycles = asid_pkg::CLK_ALU_MEM;
                end else if (with_imm) begin
                    cycles = asid_pkg::CLK_ALU_IMM;
                end else begin
                    cycles = asid_pkg::CLK_ALU_REG;
                end
            end
            asid_pkg::unpacked_decimal_add_fix, asid_pkg::packed_decimal_add_fix,
            asid_pkg::unpacked_decimal_minus_fix, asid_pkg::packed_decimal_minus_fix: begin
                cycles = asid_pkg::CLK_ADJUST;
            end
            asid_pkg::product_unsigned_op, asid_pkg::product_signed_op: begin
                if (memory) begin
                    cycles = word ? asid_pkg::CLK_PRD_MW : asid_pkg::CLK_PRD_MB;
                end else begin
                    cycles = word ? asid_pkg::CLK_PRD_RW : asid_pkg::CLK_PRD_RB;
                end
            end
            asid_pkg::product_signed_imm_op: begin
                cycles = memory ? asid_pkg::CLK_MULI_MEM : asid_pkg::CLK_MULI_REG;
            end
            asid_pkg::quotient_unsigned_op: begin
                if (memory) begin
                    cycles = word ? asid_pkg::CLK_DIV_MW : asid_pkg::CLK_DIV_MB;
                end else begin
                    cycles = word ? asid_pkg::CLK_DIV_RW : asid_pkg::CLK_DIV_RB;
                end
            end
            asid_pkg::quotient_signed_op: begin
                if (memory) begin
                    cycles = word ? asid_pkg::CLK_QUOS_MW : asid_pkg::CLK_QUOS_MB;
                end else begin
                    cycles = word ? asid_pkg::CLK_QUOS_RW : asid_pkg::CLK_QUOS_RB;
                end
            end
            asid_pkg::unpacked_decimal_product_fix: cycles = asid_pkg::CLK_PRODUCT_FIX;
            asid_pkg::unpacked_decimal_quotient_prep: begin
                cycles = asid_pkg::CLK_QUOTIENT_PREP;
            end
            asid_pkg::byte_to_word_extend, asid_pkg::word_to_doubleword_extend: begin
                cycles = asid_pkg::CLK_EXTEND;
            end
            asid_pkg::shift_by_one_op: begin
                cycles = memory ? asid_pkg::CLK_SHIFT1_MEM : asid_pkg::CLK_SHIFT1_REG;
            end
            asid_pkg::shift_by_count_low_op, asid_pkg::shift_by_imm_op: begin
                cycles = (memory ? asid_pkg::CLK_SHIFTN_MEM : asid_pkg::CLK_SHIFTN_REG)
                    + {1'b0, count_n};
            end
            asid_pkg::op_illegal: cycles = '0;
            default: cycles = '0;
        endcase
    end
endmodule

`default_nettype wire
